/* File: src/flash_ctl_pkg.sv */
package flash_ctl_pkg;

   // Flash command codes
   localparam logic [7:0] CMD_READ_ARRAY   = 8'hff;
   localparam logic [7:0] CMD_READ_STATUS  = 8'h70;
   localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
   localparam logic [7:0] CMD_PROG_SETUP   = 8'h40;
   localparam logic [7:0] CMD_PROG_ALT     = 8'h10;
   localparam logic [7:0] CMD_ERASE_SETUP  = 8'h20;
   localparam logic [7:0] CMD_CONFIRM      = 8'hd0;
   localparam logic [7:0] CMD_SUSPEND      = 8'hb0;

   // Status report bit positions
   localparam int SR_READY_BIT   = 7;
   localparam int SR_PAUSED_BIT  = 6;
   localparam int SR_EFAIL_BIT   = 5;
   localparam int SR_PFAIL_BIT   = 4;
   localparam int SR_SUPPLY_BIT  = 3;
   localparam logic [7:0] SR_RESERVED_MASK = 8'hf8;

   // Own software register offsets
   localparam logic [3:0] REG_ADDR    = 4'h0;
   localparam logic [3:0] REG_DATA    = 4'h1;
   localparam logic [3:0] REG_CMD     = 4'h2;
   localparam logic [3:0] REG_STATUS  = 4'h3;
   localparam logic [3:0] REG_RDATA   = 4'h4;

   // Operation codes written to REG_CMD
   localparam logic [2:0] OP_PROGRAM = 3'h1;
   localparam logic [2:0] OP_ERASE   = 3'h2;
   localparam logic [2:0] OP_CLEAR   = 3'h3;
   localparam logic [2:0] OP_READ    = 3'h4;
   localparam logic [2:0] OP_SUSPEND = 3'h5;
   localparam logic [2:0] OP_RESUME  = 3'h6;

   // Bus timing in ns and derived cycle counts at 200 MHz
   localparam int CLK_PERIOD_NS = 5;
   localparam int PULSE_NS      = 50;
   localparam int PULSE_CYC     = (PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READ_NS       = 120;
   localparam int READ_CYC      = (READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [7:0] PULSE_CNT = 8'(PULSE_CYC);
   localparam logic [7:0] READ_CNT  = 8'(READ_CYC);

   // Reset values
   localparam logic [18:0] ADDR_RST = 19'h00000;
   localparam logic [15:0] DATA_RST = 16'h0000;

   // Flash pin group driven by the controller
   typedef struct packed {
      logic [18:0] addr;
      logic [15:0] dq_out;
      logic        dq_oe;
      logic        ce_n;
      logic        oe_n;
      logic        we_n;
   } flash_pins_t;

   typedef enum logic [3:0] {
      ST_IDLE, ST_WR_ASSERT, ST_WR_GAP, ST_RD_ASSERT, ST_RD_GAP,
      ST_POLL_CMD, ST_POLL, ST_DONE_CLR, ST_TO_ARRAY
   } state_t;

endpackage

/* File: src/flash_ctl.sv */
// Operation
// [R01] Ready flag 0 busy, 1 idle
// [R02] Suspend sets ready and paused flags
// [R03] Erase failure sets bit 5
// [R04] Program failure sets bit 4
// [R05] Low supply sets bit 3, skips program
// [R06] Low supply on erase sets 5, 3
// [R07] Read-status before polling, read-array after; code writes read-status only after clear, read-array only in OP_READ
// [R08] Status on low byte, upper byte ignored
// [R09] Status latched at later falling select
// [R10] Toggle output enable for each poll
// [R11] Sticky error bits cleared by 50H only
// [R12] Clear status before next sequence
// [R13] Read-array needed before array reads
// [R14] Program is setup write then data
// [R15] Programming only clears bits
// [R16] During program only read-status valid
// [R17] Erase setup and confirm carry block address
// [R18] Erase sets block to ones, one block
// [R19] Erase runs four internal steps
// [R20] Check ready before error flags
// [R21] Setup code 40H or 10H accepted
// [R22] Reset clears status report
// [R23] Reserved status bits masked
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module flash_ctl
   import flash_ctl_pkg::*;
(
   input  wire logic        clk_in,          // 200 MHz clock
   input  wire logic        rst_n_in,        // Synchronous reset, active low
   input  wire logic [3:0]  sw_addr_in,      // Register address
   input  wire logic [31:0] sw_wdata_in,     // Register write data
   input  wire logic        sw_wr_in,        // Write strobe
   input  wire logic        sw_rd_in,        // Read strobe
   output logic      [31:0] sw_rdata_out,    // Read data, cycle after strobe
   output logic      [18:0] flash_addr_out,  // Flash address
   output logic      [15:0] flash_dq_out,    // Flash data driven
   output logic             flash_dq_oe_out, // High while driving data
   input  wire logic [15:0] flash_dq_in,     // Flash data sampled
   output logic             flash_ce_n_out,  // Chip select, active low
   output logic             flash_oe_n_out,  // Output enable, active low
   output logic             flash_we_n_out,  // Write enable, active low
   output logic             flash_rp_n_out   // Flash reset pin, active low
);

   // Whole controller state
   typedef struct packed {
      state_t      st;
      state_t      ret;        // State that began the read cycle
      flash_pins_t pins;
      logic [7:0]  cnt;        // Bus timing counter
      logic [2:0]  op;         // Operation in progress
      logic [1:0]  step;       // Command write index within op
      logic [18:0] addr;       // Software target address
      logic [15:0] data;       // Software write data
      logic [7:0]  status;     // Last status report seen
      logic [15:0] rdata;      // Last array word read
      logic        busy;       // Controller sequence running
      logic        ready_seen; // Completion seen in last poll
      logic [31:0] bus_rdata;
   } ctl_t;

   ctl_t s_r, s_nxt;
   logic [7:0] wr_val;    // Data value for current command write
   logic       write_req; // Software starts an operation

   // Select data for each command write in the operation
   always_comb begin
      wr_val = CMD_READ_STATUS;
      unique case (s_r.op)
         OP_PROGRAM: wr_val = (s_r.step == 2'd0) ? CMD_PROG_SETUP : s_r.data[7:0]; // [R14] [R21]
         OP_ERASE:   wr_val = (s_r.step == 2'd0) ? CMD_ERASE_SETUP : CMD_CONFIRM;  // [R17]
         OP_CLEAR:   wr_val = CMD_CLEAR_STATUS;  // [R11] [R12]
         OP_READ:    wr_val = CMD_READ_ARRAY;    // [R13]
         OP_SUSPEND: wr_val = (s_r.step == 2'd2) ? CMD_READ_STATUS : CMD_SUSPEND; // [R02] [R07] Step 2 polls after clear
         OP_RESUME:  wr_val = CMD_CONFIRM;
         default:    wr_val = CMD_READ_STATUS;
      endcase
   end

   assign write_req = sw_wr_in && (sw_addr_in == REG_CMD) && !s_r.busy;

   // Next state of the whole controller
   always_comb begin
      s_nxt = s_r;
      s_nxt.bus_rdata = 32'h00000000;
      // Register reads, answered the next cycle
      if (sw_rd_in) begin
         unique case (sw_addr_in)
            REG_ADDR:   s_nxt.bus_rdata = {13'h0000, s_r.addr};
            REG_DATA:   s_nxt.bus_rdata = {16'h0000, s_r.data};
            REG_STATUS: s_nxt.bus_rdata = {22'h000000, s_r.busy, s_r.ready_seen, s_r.status};
            REG_RDATA:  s_nxt.bus_rdata = {16'h0000, s_r.rdata};
            default:    s_nxt.bus_rdata = 32'h00000000;
         endcase
      end
      // Register writes; address and data ignored while busy
      if (sw_wr_in && !s_r.busy) begin
         if (sw_addr_in == REG_ADDR) s_nxt.addr = sw_wdata_in[18:0];
         if (sw_addr_in == REG_DATA) s_nxt.data = sw_wdata_in[15:0];
      end
      unique case (s_r.st)
         ST_IDLE: begin
            // Codes 0 and 7 are not operations and start nothing
            if (write_req && sw_wdata_in[2:0] != 3'h0 && sw_wdata_in[2:0] != 3'h7) begin
               s_nxt.op   = sw_wdata_in[2:0];
               s_nxt.step = 2'd0;
               s_nxt.busy = 1'b1;
               s_nxt.ready_seen = 1'b0;
               s_nxt.st   = ST_WR_ASSERT;
               s_nxt.cnt  = PULSE_CNT;
            end
         end
         // Command write: address, data, select and write enable low
         ST_WR_ASSERT: begin
            s_nxt.pins.addr   = s_r.addr;   // [R17]
            s_nxt.pins.dq_out = {8'h00, wr_val};
            if (s_r.op == OP_PROGRAM && s_r.step == 2'd1)
               s_nxt.pins.dq_out = s_r.data; // [R15] Zeros program, ones leave cells alone
            s_nxt.pins.dq_oe  = 1'b1;
            s_nxt.pins.ce_n   = 1'b0;
            s_nxt.pins.we_n   = 1'b0;
            s_nxt.pins.oe_n   = 1'b1;
            if (s_r.cnt == 8'h00) begin
               s_nxt.pins.we_n = 1'b1;
               s_nxt.pins.ce_n = 1'b1;
               s_nxt.cnt = PULSE_CNT;
               s_nxt.st  = ST_WR_GAP;
            end else begin
               s_nxt.cnt = s_r.cnt - 8'h01;
            end
         end
         // Recovery after write; decide next write
         ST_WR_GAP: begin
            if (s_r.cnt == 8'h00) begin
               s_nxt.pins.dq_oe = 1'b0;
               s_nxt.cnt = PULSE_CNT;
               if ((s_r.op == OP_PROGRAM || s_r.op == OP_ERASE) && s_r.step == 2'd0) begin
                  s_nxt.step = 2'd1;       // [R14] Second write follows setup
                  s_nxt.st   = ST_WR_ASSERT;
               end else if (s_r.op == OP_PROGRAM || s_r.op == OP_ERASE ||
                            s_r.op == OP_SUSPEND) begin
                  s_nxt.st = ST_POLL;       // Device already shows status
               end else if (s_r.op == OP_READ) begin
                  s_nxt.cnt = READ_CNT;
                  s_nxt.st  = ST_RD_ASSERT;
               end else if (s_r.op == OP_CLEAR) begin
                  s_nxt.st = ST_POLL_CMD;   // Refresh status view after clearing
               end else begin
                  s_nxt.busy = 1'b0;
                  s_nxt.st   = ST_IDLE;
               end
            end else begin
               s_nxt.cnt = s_r.cnt - 8'h01;
            end
         end
         // Write read-status before polling
         ST_POLL_CMD: begin
            s_nxt.op   = OP_SUSPEND;  // Reuse poll path; read-status has no second write
            s_nxt.step = 2'd2;
            s_nxt.cnt  = PULSE_CNT;
            s_nxt.st   = ST_WR_ASSERT; // [R07]
         end
         // Status poll: fresh select and output enable edge every time
         ST_POLL: begin
            s_nxt.pins.addr  = s_r.addr;
            s_nxt.pins.dq_oe = 1'b0;
            s_nxt.pins.ce_n  = 1'b0;
            s_nxt.pins.oe_n  = 1'b0;  // [R09] [R10] Falling edge latches status
            s_nxt.ret = ST_POLL;
            s_nxt.cnt = READ_CNT;
            s_nxt.st  = ST_RD_GAP;
         end
         // Array read cycle
         ST_RD_ASSERT: begin
            s_nxt.pins.addr = s_r.addr;
            s_nxt.pins.ce_n = 1'b0;
            s_nxt.pins.oe_n = 1'b0;
            s_nxt.ret = ST_RD_ASSERT;
            s_nxt.cnt = READ_CNT;
            s_nxt.st  = ST_RD_GAP;
         end
         // Wait access time, sample, then release both selects
         ST_RD_GAP: begin
            if (s_r.cnt == 8'h00) begin
               s_nxt.pins.oe_n = 1'b1;
               s_nxt.pins.ce_n = 1'b1;   // [R10] Toggle before next poll
               if (s_r.ret == ST_RD_ASSERT) begin
                  s_nxt.rdata = flash_dq_in;
                  s_nxt.busy  = 1'b0;
                  s_nxt.st    = ST_IDLE;
               end else begin
                  s_nxt.status = flash_dq_in[7:0] & SR_RESERVED_MASK; // [R08] [R23]
                  if (flash_dq_in[SR_READY_BIT]) begin               // [R01] [R20]
                     s_nxt.ready_seen = 1'b1;
                     s_nxt.st = ST_DONE_CLR;
                  end else begin
                     s_nxt.cnt = PULSE_CNT;
                     s_nxt.st  = ST_POLL;   // [R16] Only status reads while busy
                  end
               end
            end else begin
               s_nxt.cnt = s_r.cnt - 8'h01;
            end
         end
         // Status captured; error flags now valid to software
         ST_DONE_CLR: begin
            // Paused erase keeps device status mode; no read-array here
            s_nxt.busy = 1'b0;       // [R03] [R04] [R05] [R06] [R02] [R18] [R19]
            s_nxt.st   = ST_IDLE;    // [R13] Software issues OP_READ for array data
         end
         default: s_nxt.st = ST_IDLE;
      endcase
   end

   // Register the whole state
   always_ff @(posedge clk_in) begin
      if (!rst_n_in) begin
         s_r <= '0;
         s_r.st   <= ST_IDLE;
         s_r.ret  <= ST_IDLE;
         s_r.pins <= '{addr: ADDR_RST, dq_out: DATA_RST, dq_oe: 1'b0,
                       ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1};
      end else begin
         s_r <= s_nxt;
      end
   end

   assign sw_rdata_out    = s_r.bus_rdata;
   assign flash_addr_out  = s_r.pins.addr;
   assign flash_dq_out    = s_r.pins.dq_out;
   assign flash_dq_oe_out = s_r.pins.dq_oe;
   assign flash_ce_n_out  = s_r.pins.ce_n;
   assign flash_oe_n_out  = s_r.pins.oe_n;
   assign flash_we_n_out  = s_r.pins.we_n;
   assign flash_rp_n_out  = rst_n_in;  // [R22] Controller reset clears flash status

endmodule // flash_ctl

/* File: testbench/flash_dev_model.sv */
`timescale 1ns/100ps
// Behavioural flash part: command decoder, write sequencer, status report
module flash_dev_model
   import flash_ctl_pkg::*;
(
   input  wire logic [18:0] addr_in,
   input  wire logic [15:0] dq_in,
   input  wire logic        ce_n_in,
   input  wire logic        oe_n_in,
   input  wire logic        we_n_in,
   input  wire logic        rp_n_in,
   input  wire logic        low_in,     // Supply out of range
   input  wire logic        fail_in,    // Next sequence fails verify
   input  var  int          busy_ns_in, // Sequence length
   output logic      [15:0] dq_out
);
   logic [7:0]  sr = 8'h80;            // Status report
   logic [7:0]  lat;                   // Status held for one read
   logic [15:0] mem [16];              // One small block
   logic [15:0] last;                  // Last value shown on the bus
   logic        stat_md, psu, esu;     // Status mode, pending setups
   int          fb;                    // Fail bit of running sequence
   event        go;
   initial foreach (mem[i]) mem[i] = 16'hffff;
   // Commands land when select or write strobe rises, whichever comes first;
   // both may rise in one step, so the pair is watched as one signal
   wire         wr_act = !ce_n_in && !we_n_in;
   always @(negedge wr_act) if (rp_n_in) begin
      if (psu) begin
         psu = 0;
         stat_md = 1;
         if (low_in) sr[3] = 1;
         else begin
            mem[addr_in[3:0]] &= dq_in;
            fb = 4;
            ->go;
         end
      end else if (esu && dq_in[7:0] == 8'hd0) begin
         esu = 0;
         stat_md = 1;
         if (low_in) sr[5:3] = 3'h5;
         else begin
            foreach (mem[i]) mem[i] = 16'hffff;
            fb = 5;
            ->go;
         end
      end else if (sr[7] || dq_in[7:0] inside {8'h70, 8'hb0}) begin
         esu = 0;
         case (dq_in[7:0])
            8'hff: stat_md = 0;
            8'h70: stat_md = 1;
            8'h50: sr[5:3] = 0;
            8'h40, 8'h10: psu = 1;
            8'h20: esu = 1;
            8'hb0: begin
               stat_md = 1;
               if (!sr[7]) sr[7:6] = 2'h3;
            end
            8'hd0: if (sr[6]) sr[7:6] = 2'h0;
            default: ;
         endcase
      end
   end
   // Sequencer timer; a paused erase waits for resume
   always @(go) begin
      sr[7] = 0;
      #(busy_ns_in);
      wait (!sr[6]);
      sr[7] = 1;
      if (fail_in) sr[fb] = 1;
   end
   always @(negedge rp_n_in) begin
      sr = 8'h80;
      {stat_md, psu, esu} = 3'h0;
   end
   // Capture at the later falling select so the value cannot move mid-read
   always @(negedge ce_n_in or negedge oe_n_in) if (!ce_n_in && !oe_n_in) lat = sr;
   always @* if (!ce_n_in && !oe_n_in) last = stat_md ? {8'h00, lat} : mem[addr_in[3:0]];
   // Released bus shows the inverse so stale data is never mistaken
   assign dq_out = (!ce_n_in && !oe_n_in) ? last : ~last;
endmodule // flash_dev_model

/* File: testbench/flash_ctl_assertions.sv */
`timescale 1ns/100ps
// Watches the flash pins and register port of the controller
module flash_ctl_assertions
   import flash_ctl_pkg::*;
(
   input wire logic        clk_in,
   input wire logic        rst_n_in,
   input wire logic [3:0]  sw_addr_in,
   input wire logic        sw_rd_in,
   input wire logic [31:0] sw_rdata_out,
   input wire logic [18:0] flash_addr_out,
   input wire logic [15:0] flash_dq_out,
   input wire logic        flash_dq_oe_out,
   input wire logic        flash_ce_n_out,
   input wire logic        flash_oe_n_out,
   input wire logic        flash_we_n_out,
   input wire logic        flash_rp_n_out
);
   default clocking @(posedge clk_in); endclocking
   default disable iff (!rst_n_in);
   // Write strobe low with bus frozen; with the falling cycle the strobe is low ten cycles
   sequence wr_hold_s;
      (!flash_we_n_out && $stable(flash_dq_out) && $stable(flash_addr_out))[*8] ##1
      (!flash_we_n_out && $stable(flash_dq_out) && $stable(flash_addr_out));
   endsequence
   // Read select low with address frozen
   sequence rd_hold_s;
      (!flash_oe_n_out && $stable(flash_addr_out))[*8];
   endsequence
   a_wr_pulse: assert property ($fell(flash_we_n_out) |=> wr_hold_s ##1 flash_we_n_out)
      else $error("write strobe length or bus hold wrong");
   a_wr_gap: assert property ($rose(flash_we_n_out) |-> flash_we_n_out[*8])
      else $error("write strobes too close");
   a_wr_select: assert property (!flash_we_n_out |-> !flash_ce_n_out && flash_dq_oe_out && flash_oe_n_out)
      else $error("write strobe without select or data drive");
   a_rd_select: assert property (!flash_oe_n_out |-> !flash_ce_n_out && !flash_dq_oe_out)
      else $error("read with bus contention or no select");
   a_rd_hold: assert property ($fell(flash_oe_n_out) |=> rd_hold_s ##1 rd_hold_s ##1 rd_hold_s)
      else $error("read cycle cut short");
   a_poll_toggle: assert property ($rose(flash_oe_n_out) |-> $rose(flash_ce_n_out))
      else $error("poll does not toggle select");
   a_rp_reset: assert property (disable iff (1'b0) flash_rp_n_out == rst_n_in)
      else $error("flash reset pin not following reset");
   a_status_mask: assert property ($past(sw_rd_in) && $past(sw_addr_in) == REG_STATUS |->
      sw_rdata_out[2:0] == 3'h0)
      else $error("reserved status bits not zero");
endmodule // flash_ctl_assertions
bind flash_ctl flash_ctl_assertions u_chk (.clk_in, .rst_n_in, .sw_addr_in, .sw_rd_in, .sw_rdata_out,
   .flash_addr_out, .flash_dq_out, .flash_dq_oe_out, .flash_ce_n_out, .flash_oe_n_out, .flash_we_n_out,
   .flash_rp_n_out);

/* File: testbench/flash_ctl_bench.sv */
`timescale 1ns/100ps
module flash_ctl_bench;
   import flash_ctl_pkg::*;
   logic        clk_in = 0, rst_n_in = 0, sw_wr_in = 0, sw_rd_in = 0, low = 0, fail = 0;
   logic [3:0]  sw_addr_in = 0, a;
   logic [31:0] sw_wdata_in = 0, sw_rdata_out, rd;
   logic [18:0] flash_addr_out;
   logic [15:0] flash_dq_out, dev_dq, flash_dq_in, d;
   logic        flash_dq_oe_out, flash_ce_n_out, flash_oe_n_out, flash_we_n_out, flash_rp_n_out;
   logic [7:0]  exp_sr;               // Expected status report
   int          busy_ns = 60, err_total = 0, cmp_count = 0;
   int          mem_m [16];           // Expected array contents
   // Data wire: controller when it drives, else the part
   assign flash_dq_in = flash_dq_oe_out ? flash_dq_out : dev_dq;
   flash_ctl dut (.clk_in, .rst_n_in, .sw_addr_in, .sw_wdata_in, .sw_wr_in, .sw_rd_in, .sw_rdata_out,
      .flash_addr_out, .flash_dq_out, .flash_dq_oe_out, .flash_dq_in, .flash_ce_n_out, .flash_oe_n_out,
      .flash_we_n_out, .flash_rp_n_out);
   flash_dev_model dev (.addr_in(flash_addr_out), .dq_in(flash_dq_in), .ce_n_in(flash_ce_n_out),
      .oe_n_in(flash_oe_n_out), .we_n_in(flash_we_n_out), .rp_n_in(flash_rp_n_out), .low_in(low),
      .fail_in(fail), .busy_ns_in(busy_ns), .dq_out(dev_dq));
   initial forever #2.5 clk_in = ~clk_in;
   task automatic chk(input logic [31:0] seen, input logic [31:0] want);
      cmp_count++;
      if (seen !== want) begin
         err_total++;
         $display("unexpected at %0t: saw %h want %h", $time, seen, want);
      end
   endtask
   task automatic wr(input logic [3:0] ad, input logic [31:0] dt);
      @(posedge clk_in);
      sw_addr_in <= ad;
      sw_wdata_in <= dt;
      sw_wr_in <= 1;
      @(posedge clk_in);
      sw_wr_in <= 0;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rdr(input logic [3:0] ad);
      @(posedge clk_in);
      sw_addr_in <= ad;
      sw_rd_in <= 1;
      @(posedge clk_in);
      sw_rd_in <= 0;
      #1 rd = sw_rdata_out;
   endtask
   // Start an operation and wait, bounded, until it is no longer busy
   task automatic op(input logic [2:0] o, input logic [3:0] ad, input logic [15:0] dt);
      wr(REG_ADDR, {28'h0, ad});
      wr(REG_DATA, {16'h0, dt});
      wr(REG_CMD, {29'h0, o});
      rd = '1;  // Stale idle status from an earlier op must not end the wait
      for (int i = 0; i < 3000 && rd[9] !== 1'b0; i++) rdr(REG_STATUS);
      chk(rd[9], 1'b0);
   endtask
   task automatic give_verdict;
      $display("comparisons %0d mismatches %0d", cmp_count, err_total);
      if (err_total == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #200_000;  // Several times the expected run length
      err_total++;
      give_verdict;
   end
   initial begin
      void'($urandom(32'hb1fa));
      foreach (mem_m[i]) mem_m[i] = 'hffff;
      repeat (10) @(posedge clk_in);
      rst_n_in <= 1;
      rdr(4'hf);
      chk(rd, 0);
      rdr(REG_STATUS);
      chk(rd & 32'h200, 0);
      // Good, low-supply and failing runs of program, then of erase
      for (int k = 0; k < 6; k++) begin
         a = 4'($urandom());
         d = 16'($urandom());
         low <= (k % 3 == 1);
         fail <= (k % 3 == 2);
         busy_ns = (k < 3) ? 60 : 2000;
         rd = '1;
         if (k < 3) begin
            op(OP_PROGRAM, a, d);
            exp_sr = low ? 8'h88 : fail ? 8'h90 : 8'h80;
            if (!low) mem_m[a] &= d;
         end else begin
            op(OP_ERASE, a, d);
            exp_sr = low ? 8'ha8 : fail ? 8'ha0 : 8'h80;
            if (!low) foreach (mem_m[i]) mem_m[i] = 'hffff;
         end
         chk(rd[7:0], exp_sr);
         op(OP_READ, a, 0);
         op(OP_SUSPEND, a, 0);
         chk(rd[7:0], exp_sr);
         op(OP_CLEAR, a, 0);
         chk(rd[7:0], 8'h80);
         op(OP_READ, a, 0);
         rdr(REG_RDATA);
         chk(rd, mem_m[a]);
         $display("test %0d done", k);
      end
      wr(REG_CMD, 0);
      wr(REG_CMD, 7);
      rdr(REG_STATUS);
      chk(rd[9], 1'b0);
      // Sticky flag left set, then a reset while idle must clear both sides
      low <= 1;
      op(OP_PROGRAM, a, 0);
      chk(rd[7:0], 8'h88);
      @(posedge clk_in);
      rst_n_in <= 0;
      low <= 0;
      repeat (10) @(posedge clk_in);
      rst_n_in <= 1;
      rdr(REG_STATUS);
      chk(rd, 0);
      op(OP_SUSPEND, a, 0);
      chk(rd[7:0], 8'h80);
      $display("reset test done");
      op(OP_RESUME, a, 0);
      chk(rd[7:0], 8'h80);
      give_verdict;
   end
endmodule // flash_ctl_bench
